// [rhbw_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// Host processor on the muxed bus
// ****************************************
module rhbw_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Bus pins
  output logic            addr_strobe,
  output logic            chip_sel_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic [7:0]      bus_to_dev,
  input  wire logic [7:0] dev_bus_o,
  input  wire logic       dev_bus_oe
);
  logic       drv_q;
  logic [7:0] val_q;
  logic [7:0] idle_q;
  initial begin
    addr_strobe = 1'b0;
    chip_sel_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    drv_q = 1'b0;
    val_q = 8'h00;
    idle_q = 8'h5A;
  end
  // Released bus flips every cycle
  always @(posedge clk_sys) idle_q <= ~idle_q;
  assign bus_to_dev = dev_bus_oe ? dev_bus_o : (drv_q ? val_q : idle_q);
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Address first on the shared lines
  task automatic addr_phase(input logic [7:0] a);
    addr_strobe = 1'b1;
    drv_q = 1'b1;
    val_q = a;
    gap(3);
    addr_strobe = 1'b0;
    gap(3);
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic sel);
    addr_phase(a);
    val_q = d;
    chip_sel_n = sel;
    write_strobe_n = 1'b0;
    gap(6);
    write_strobe_n = 1'b1;
    gap(3);
    chip_sel_n = 1'b1;
    drv_q = 1'b0;
    gap(4);
  endtask
  task automatic bus_read(input logic [7:0] a, input logic sel, output logic [7:0] q);
    addr_phase(a);
    drv_q = 1'b0;
    chip_sel_n = sel;
    read_strobe_n = 1'b0;
    gap(8);
    q = bus_to_dev;
    read_strobe_n = 1'b1;
    gap(1);
    chip_sel_n = 1'b1;
    gap(6);
  endtask
endmodule

// [rhbw_host_port.sv]
`timescale 1ns/1ps

// What this block does
// - With main supply absent, kickstart (when aux_battery_enable is set) or wake interrupt asserts power-on output.
// - With main supply present, software power bit sets the power-on output.
// - Kickstart falling edge without main supply requests system power-on when aux_battery_enable is set.
// - With main supply present, kickstart falling edge is an interrupt source.
// - Address strobe without chip select latches address, moves no data.
// - Address is latched from the bus on address strobe falling edge.
// - Bus data is written to the addressed register as the write strobe rises.
// - Bus drivers are enabled with read data only while read strobe low.
// - Supply select high gives fixed 5V mode, else autosense mode.
// - Interrupt output is low while any enabled status flag is set.
// - Interrupt output floats whenever no enabled condition exists.
// - Interrupt output is active-low open drain, shareable on a wire.
// - Read ends and bus floats as the read strobe rises.
// - Same eight lines carry address first, then data.
module rhbw_host_port (
  // Clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  // Host bus pins
  input  wire logic                              addr_strobe,
  input  wire logic                              chip_sel_n,
  input  wire logic                              read_strobe_n,
  input  wire logic                              write_strobe_n,
  input  wire logic [rhbw_pkg::RHBW_BUS_W-1:0]   muxed_addr_data_bus_i,
  output logic      [rhbw_pkg::RHBW_BUS_W-1:0]   muxed_addr_data_bus_o,
  output logic                                   muxed_addr_data_bus_oe,
  // Register side
  output rhbw_pkg::rhbw_req_t                    reg_req,
  input  wire logic [rhbw_pkg::RHBW_BUS_W-1:0]   reg_rdata,
  // Interrupt request
  input  wire logic [rhbw_pkg::RHBW_BUS_W-1:0]   irq_flags,
  input  wire logic [rhbw_pkg::RHBW_BUS_W-1:0]   irq_enables,
  output logic                                   irq_n_o,
  output logic                                   irq_n_oe,
  // Power control
  input  wire logic                              vcc_present,
  input  wire logic                              kickstart_n,
  input  wire logic                              wake_irq,
  input  wire logic                              aux_battery_enable,
  input  wire logic                              sw_power_on,
  output logic                                   power_on_request_n,
  output logic                                   kickstart_irq,
  // Supply select
  input  wire logic                              supply_sel,
  output logic                                   fixed_5v_mode,
  output logic                                   autosense_mode
);
  import rhbw_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  rhbw_ctl_t             ctl_pin;
  rhbw_ctl_t             ctl_s1_q;
  rhbw_ctl_t             ctl_s2_q;
  rhbw_ctl_t             ctl_s3_q;
  logic [RHBW_BUS_W-1:0] bus_s1_q;
  logic [RHBW_BUS_W-1:0] bus_s2_q;

  always_comb begin
    ctl_pin                = RHBW_CTL_IDLE;
    ctl_pin.addr_strobe    = addr_strobe;
    ctl_pin.chip_sel_n     = chip_sel_n;
    ctl_pin.read_strobe_n  = read_strobe_n;
    ctl_pin.write_strobe_n = write_strobe_n;
    ctl_pin.kickstart_n    = kickstart_n;
    ctl_pin.supply_sel     = supply_sel;
    ctl_pin.vcc_present    = vcc_present;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_s1_q <= RHBW_CTL_IDLE;
      ctl_s2_q <= RHBW_CTL_IDLE;
      ctl_s3_q <= RHBW_CTL_IDLE;
      bus_s1_q <= RHBW_BUS_RST;
      bus_s2_q <= RHBW_BUS_RST;
    end else begin
      ctl_s1_q <= ctl_pin;
      ctl_s2_q <= ctl_s1_q;
      ctl_s3_q <= ctl_s2_q;
      bus_s1_q <= muxed_addr_data_bus_i;
      bus_s2_q <= bus_s1_q;
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  logic ale_fall;
  logic rd_fall;
  logic wr_fall;
  logic ks_fall;
  logic selected;

  always_comb begin
    ale_fall = ctl_s3_q.addr_strobe & ~ctl_s2_q.addr_strobe;
    rd_fall  = ctl_s3_q.read_strobe_n & ~ctl_s2_q.read_strobe_n;
    wr_fall  = ctl_s3_q.write_strobe_n & ~ctl_s2_q.write_strobe_n;
    ks_fall  = ctl_s3_q.kickstart_n & ~ctl_s2_q.kickstart_n;
    selected = ~ctl_s2_q.chip_sel_n;
  end

  // ****************************************
  // Bus cycle engine
  // ****************************************
  rhbw_bus_st_t          st_q;
  rhbw_bus_st_t          st_d;
  rhbw_req_t             req_q;
  rhbw_req_t             req_d;
  logic [RHBW_BUS_W-1:0] wdata_q;
  logic [RHBW_BUS_W-1:0] wdata_d;
  logic [RHBW_BUS_W-1:0] dout_q;
  logic [RHBW_BUS_W-1:0] dout_d;
  logic                  oe_q;
  logic                  oe_d;

  always_comb begin
    st_d    = st_q;
    req_d   = req_q;
    req_d.we = 1'b0;
    req_d.re = 1'b0;
    wdata_d = wdata_q;
    dout_d  = dout_q;
    oe_d    = 1'b0;
    if (ale_fall) begin
      req_d.addr = bus_s2_q;
    end
    case (st_q)
      RHBW_IDLE: begin
        if (rd_fall && selected) begin
          st_d     = RHBW_READ;
          req_d.re = 1'b1;
        end else if (wr_fall && selected) begin
          st_d    = RHBW_WRITE;
          wdata_d = bus_s2_q;
        end
      end
      RHBW_READ: begin
        if (ctl_s2_q.read_strobe_n || !selected) begin
          st_d = RHBW_IDLE;
        end else begin
          oe_d   = 1'b1;
          dout_d = reg_rdata;
        end
      end
      RHBW_WRITE: begin
        if (!selected) begin
          st_d = RHBW_IDLE;
        end else if (ctl_s2_q.write_strobe_n) begin
          st_d       = RHBW_IDLE;
          req_d.we   = 1'b1;
          req_d.data = wdata_q;
        end else begin
          wdata_d = bus_s2_q;
        end
      end
      default: begin
        st_d = RHBW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= RHBW_IDLE;
      req_q   <= RHBW_REQ_RST;
      wdata_q <= RHBW_BUS_RST;
      dout_q  <= RHBW_BUS_RST;
      oe_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      req_q   <= req_d;
      wdata_q <= wdata_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
    end
  end

  assign reg_req                = req_q;
  assign muxed_addr_data_bus_o  = dout_q;
  assign muxed_addr_data_bus_oe = oe_q;

  // ****************************************
  // Interrupt request and supply mode
  // ****************************************
  logic irq_oe_q;
  logic irq_oe_d;
  logic fixed_q;
  logic fixed_d;
  logic auto_q;
  logic auto_d;

  always_comb begin
    irq_oe_d = |(irq_flags & irq_enables);
    fixed_d  = ctl_s2_q.supply_sel;
    auto_d   = ~ctl_s2_q.supply_sel;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_oe_q <= 1'b0;
      fixed_q  <= 1'b0;
      auto_q   <= 1'b1;
    end else begin
      irq_oe_q <= irq_oe_d;
      fixed_q  <= fixed_d;
      auto_q   <= auto_d;
    end
  end

  assign irq_n_o        = RHBW_IRQ_LVL;
  assign irq_n_oe       = irq_oe_q;
  assign fixed_5v_mode  = fixed_q;
  assign autosense_mode = auto_q;

  // ****************************************
  // Power-on and kickstart
  // ****************************************
  logic pwr_n_q;
  logic pwr_n_d;
  logic ks_irq_q;
  logic ks_irq_d;

  always_comb begin
    pwr_n_d  = pwr_n_q;
    ks_irq_d = 1'b0;
    if (ctl_s2_q.vcc_present) begin
      pwr_n_d  = ~sw_power_on;
      ks_irq_d = ks_fall;
    end else if ((ks_fall && aux_battery_enable) || wake_irq) begin
      pwr_n_d  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_n_q  <= ~RHBW_PWR_RST;
      ks_irq_q <= 1'b0;
    end else begin
      pwr_n_q  <= pwr_n_d;
      ks_irq_q <= ks_irq_d;
    end
  end

  assign power_on_request_n = pwr_n_q;
  assign kickstart_irq      = ks_irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_addr_capture;
    @(posedge clk_sys) disable iff (!rst_n)
      ale_fall |=> (reg_req.addr == $past(bus_s2_q));
  endproperty
  a_addr_capture: assert property (p_addr_capture)
    else $error("address not latched on strobe fall");

  property p_no_data_unselected;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_req.we || reg_req.re) |-> !$past(ctl_s2_q.chip_sel_n);
  endproperty
  a_no_data_unselected: assert property (p_no_data_unselected)
    else $error("data moved without chip select");

  property p_oe_in_read;
    @(posedge clk_sys) disable iff (!rst_n)
      muxed_addr_data_bus_oe |-> $past(!ctl_s2_q.read_strobe_n && !ctl_s2_q.chip_sel_n);
  endproperty
  a_oe_in_read: assert property (p_oe_in_read)
    else $error("bus driven outside read strobe");

  property p_read_release;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == RHBW_READ && ctl_s2_q.read_strobe_n) |=> !muxed_addr_data_bus_oe [*2];
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("bus not released after read");

  property p_write_commit;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == RHBW_WRITE && ctl_s2_q.write_strobe_n && !ctl_s2_q.chip_sel_n)
        |=> reg_req.we && (reg_req.data == $past(wdata_q)) ##1 !reg_req.we;
  endproperty
  a_write_commit: assert property (p_write_commit)
    else $error("write not committed at strobe end");

  property p_irq_assert;
    @(posedge clk_sys) disable iff (!rst_n)
      (|(irq_flags & irq_enables)) |=> (irq_n_oe && !irq_n_o);
  endproperty
  a_irq_assert: assert property (p_irq_assert)
    else $error("interrupt not driven low");

  property p_irq_float;
    @(posedge clk_sys) disable iff (!rst_n)
      !(|(irq_flags & irq_enables)) |=> !irq_n_oe;
  endproperty
  a_irq_float: assert property (p_irq_float)
    else $error("interrupt driven with no condition");

  property p_ks_wake;
    @(posedge clk_sys) disable iff (!rst_n)
      (!ctl_s2_q.vcc_present && aux_battery_enable && ks_fall) |=> !power_on_request_n;
  endproperty
  a_ks_wake: assert property (p_ks_wake)
    else $error("kickstart did not request power");

  property p_ks_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctl_s2_q.vcc_present && ks_fall) |=> kickstart_irq ##1 !kickstart_irq;
  endproperty
  a_ks_irq: assert property (p_ks_irq)
    else $error("kickstart interrupt pulse missing");

  property p_sw_power;
    @(posedge clk_sys) disable iff (!rst_n)
      ctl_s2_q.vcc_present |=> (power_on_request_n == !$past(sw_power_on));
  endproperty
  a_sw_power: assert property (p_sw_power)
    else $error("power output ignores software bit");

  property p_supply_mode;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(ctl_s2_q.supply_sel)
        |=> (fixed_5v_mode == $past(ctl_s2_q.supply_sel)) && (autosense_mode != fixed_5v_mode);
  endproperty
  a_supply_mode: assert property (p_supply_mode)
    else $error("supply mode does not follow select");

endmodule

// [rhbw_host_port_tb.sv]
`timescale 1ns/1ps
module rhbw_host_port_tb;
  import rhbw_pkg::*;
  logic clk_sys, rst_n, ale, cs_n, rd_n, wr_n, oe, irq_o, irq_oe, vcc, ks_n, wake, aux, sw_on;
  logic pwr_n, ks_irq, psel, f5v, auto_m;
  logic [7:0] bus_in, bus_out, flags, enables, q, a, d;
  rhbw_req_t rq;
  int err_total, samples_checked, we_n, oe_n, ksi_n, re_n;
  logic [7:0] we_a, we_d;
  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    return x ^ 8'hC3;
  endfunction
  rhbw_host_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr_strobe(ale),
    .chip_sel_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .muxed_addr_data_bus_i(bus_in), .muxed_addr_data_bus_o(bus_out),
    .muxed_addr_data_bus_oe(oe), .reg_req(rq), .reg_rdata(exp_rd(rq.addr)),
    .irq_flags(flags), .irq_enables(enables), .irq_n_o(irq_o), .irq_n_oe(irq_oe),
    .vcc_present(vcc), .kickstart_n(ks_n), .wake_irq(wake), .aux_battery_enable(aux),
    .sw_power_on(sw_on), .power_on_request_n(pwr_n), .kickstart_irq(ks_irq),
    .supply_sel(psel), .fixed_5v_mode(f5v), .autosense_mode(auto_m));
  rhbw_host_model host_u (.clk_sys(clk_sys), .addr_strobe(ale), .chip_sel_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .bus_to_dev(bus_in),
    .dev_bus_o(bus_out), .dev_bus_oe(oe));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Monitor and checks
  // ****************************************
  always @(negedge clk_sys) begin
    if (rq.re === 1'b1) re_n++;
    if (rq.we === 1'b1) begin
      we_n++;
      we_a = rq.addr;
      we_d = rq.data;
    end
    if (oe === 1'b1) oe_n++;
    if (ks_irq === 1'b1) ksi_n++;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end
  initial begin
    {rst_n, vcc, ks_n, wake, aux, sw_on, psel} = 7'b0010000;
    {flags, enables, err_total, samples_checked, we_n, oe_n, ksi_n, re_n} = '0;
    void'($urandom(42));
    cyc(16);
    rst_n = 1'b1;
    cyc(4);
    // ****************************************
    // Bus writes and reads
    // ****************************************
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hFF : 8'($urandom);
      d = (i == 0) ? 8'h00 : 8'($urandom);
      host_u.bus_write(a, d, 1'b0);
      chk(8'(we_n), 8'(i + 1));
      chk(we_a, a);
      chk(we_d, d);
      host_u.bus_read(a, 1'b0, q);
      chk(q, exp_rd(a));
      chk(8'(re_n), 8'(i + 1));
      chk({7'h00, oe}, 8'h00);
    end
    $display("test bus done");
    oe_n = 0;
    a = 8'h3C;
    host_u.bus_write(a, 8'hA5, 1'b1);
    chk(rq.addr, a);
    chk(8'(we_n), 8'h08);
    host_u.bus_read(8'h42, 1'b1, q);
    chk(rq.addr, 8'h42);
    chk(8'(oe_n), 8'h00);
    chk(8'(re_n), 8'h08);
    $display("test no select done");
    // ****************************************
    // Interrupt request
    // ****************************************
    for (int i = 0; i < 10; i++) begin
      flags = (i == 0) ? 8'h01 : 8'($urandom);
      enables = (i == 0) ? 8'h00 : 8'($urandom);
      cyc(3);
      chk({7'h00, irq_oe}, {7'h00, |(flags & enables)});
      chk({7'h00, irq_o}, 8'h00);
      flags = flags & ~enables;
      cyc(3);
      chk({7'h00, irq_oe}, 8'h00);
    end
    $display("test irq done");
    // ****************************************
    // Power control and supply select
    // ****************************************
    ks_n = 1'b0;
    cyc(4);
    ks_n = 1'b1;
    cyc(5);
    chk({7'h00, pwr_n}, 8'h01);
    aux = 1'b1;
    ks_n = 1'b0;
    cyc(4);
    ks_n = 1'b1;
    cyc(5);
    chk({7'h00, pwr_n}, 8'h00);
    chk(8'(ksi_n), 8'h00);
    vcc = 1'b1;
    cyc(6);
    chk({7'h00, pwr_n}, 8'h01);
    sw_on = 1'b1;
    cyc(3);
    chk({7'h00, pwr_n}, 8'h00);
    ks_n = 1'b0;
    cyc(4);
    ks_n = 1'b1;
    cyc(6);
    chk(8'(ksi_n), 8'h01);
    sw_on = 1'b0;
    cyc(3);
    chk({7'h00, pwr_n}, 8'h01);
    vcc = 1'b0;
    cyc(5);
    wake = 1'b1;
    cyc(3);
    chk({7'h00, pwr_n}, 8'h00);
    $display("test power done");
    for (int v = 1; v >= 0; v--) begin
      psel = v[0];
      cyc(5);
      chk({7'h00, f5v}, 8'(v));
      chk({7'h00, auto_m}, 8'(1 - v));
    end
    $display("test supply select done");
    give_verdict();
  end
endmodule

// [rhbw_pkg.sv]
package rhbw_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int RHBW_BUS_W = 8;

  // ****************************************
  // Reset values and interrupt drive level
  // ****************************************
  localparam logic [RHBW_BUS_W-1:0] RHBW_BUS_RST  = 8'h00;
  localparam logic                  RHBW_PWR_RST  = 1'b0;
  localparam logic                  RHBW_IRQ_LVL  = 1'b0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic addr_strobe;
    logic chip_sel_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic kickstart_n;
    logic supply_sel;
    logic vcc_present;
  } rhbw_ctl_t;

  localparam rhbw_ctl_t RHBW_CTL_IDLE = '{
    addr_strobe:    1'b0,
    chip_sel_n:     1'b1,
    read_strobe_n:  1'b1,
    write_strobe_n: 1'b1,
    kickstart_n:    1'b1,
    supply_sel:     1'b0,
    vcc_present:    1'b0
  };

  typedef struct packed {
    logic [RHBW_BUS_W-1:0] addr;
    logic [RHBW_BUS_W-1:0] data;
    logic                  we;
    logic                  re;
  } rhbw_req_t;

  localparam rhbw_req_t RHBW_REQ_RST = '{
    addr: RHBW_BUS_RST,
    data: RHBW_BUS_RST,
    we:   1'b0,
    re:   1'b0
  };

  typedef enum logic [1:0] {
    RHBW_IDLE,
    RHBW_READ,
    RHBW_WRITE
  } rhbw_bus_st_t;

endpackage
